// [design/fsl_host_ctrl.sv]
// Host-side controller for a parallel NOR flash: runs status reads,
// lockdown, suspend/resume, security register and query commands.
// Assumes a software master on the plain register port and the flash pins
// wired straight to the device; ready/busy is pulled up outside.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// Functional notes
// - After failure flag, host issues identification exit
// - Supply-low flag; host then issues identification exit
// - Host resumes erase with one write
// - Suspend and resume are single writes
// - Lock command carries lock bit zero
// - Host exits identification before suspend, resume, lockdown and security register operations
// - Address before strobe fall, data past rise
module fsl_host_ctrl #(
	parameter int SUSP_WAIT = fsl_pkg::SUSP_CYC    // Cycles allowed for suspend
) (
	input  wire logic        CLK_SYS,              // System clock, 10 MHz
	input  wire logic        RESET,                // Synchronous reset, high
	input  wire logic [2:0]  SW_ADDR,              // Register offset
	input  wire logic [31:0] SW_WDATA,             // Register write data
	input  wire logic        SW_WR,                // Write strobe
	input  wire logic        SW_RD,                // Read strobe
	output logic      [31:0] SW_RDATA,             // Read data, cycle after strobe
	output logic      [19:0] FL_ADDR,              // Flash address
	output logic      [15:0] FL_DQ_O,              // Flash data out
	input  wire logic [15:0] FL_DQ_I,              // Flash data in
	output logic             FL_DQ_OE_N,           // Low while host drives data
	output logic             FL_CE_N,              // Chip select
	output logic             FL_WE_N,              // Write strobe
	output logic             FL_OE_N,              // Output enable
	output logic             FL_RESET_N,           // Device reset
	input  wire logic        FL_READY              // Ready/busy line
);
	typedef enum logic [2:0] {S_IDLE, S_EXIT, S_STEP, S_WAIT, S_CHECK, S_SUSP} fsl_st_t;

	fsl_st_t           state_q;                    // Sequencer state
	fsl_pkg::fsl_op_t  op_q;                       // Operation in progress
	logic [2:0]        step_q;                     // Bus cycle within the operation
	logic              exit_q;                     // Engine is running an exit write
	logic              post_q;                     // Exit ends the operation
	logic              mode_q;                     // Device outside array read mode
	logic              fail_q, vpp_q;              // Flags from the last status read
	logic              susp_q;                     // Suspend in effect
	logic              err_q;                      // Refused command, sticky
	logic [15:0]       cnt_q;                      // Suspend wait counter
	logic [19:0]       uaddr_q;                    // Operand address
	logic [15:0]       udata_q, rdata_q;           // Operand and result data
	logic              cmd_wr;                     // Software wrote the command register
	logic              cmd_legal;                  // Opcode known
	fsl_pkg::fsl_op_t  cmd_op;                     // Decoded opcode
	fsl_pkg::fsl_op_t  eng_op;                     // Operation feeding the engine
	logic [2:0]        eng_step;                   // Step feeding the engine
	logic              eng_start, eng_done, rdy_s; // Engine handshake
	logic [35:0]       eng_word;                   // Address and data of the step
	logic [15:0]       eng_rdata;                  // Engine read data

	// Bus cycles making up each operation
	function automatic logic [2:0] op_len(input fsl_pkg::fsl_op_t op);
		unique case (op)
			fsl_pkg::OP_IDENT_ENTRY: op_len = 3'd3;
			fsl_pkg::OP_PROG_SECREG, fsl_pkg::OP_LOCK_SECREG: op_len = 3'd4;
			fsl_pkg::OP_SECT_LOCK: op_len = 3'd6;
			default: op_len = 3'd1;
		endcase
	endfunction

	// Address and data of one bus cycle; codes sit in the low byte
	function automatic logic [35:0] step_word(input fsl_pkg::fsl_op_t op,
			input logic [2:0] k, input logic [19:0] ua, input logic [15:0] ud);
		logic [7:0] code;
		code = fsl_pkg::CMD_UNLK1;
		step_word = {fsl_pkg::UNLOCK_A1, 8'h00, code};
		if (k == 3'd1 || k == 3'd4) begin                 // Second unlock write
			step_word = {fsl_pkg::UNLOCK_A2, 8'h00, fsl_pkg::CMD_UNLK2};
		end
		unique case (op)
			fsl_pkg::OP_READ, fsl_pkg::OP_STATUS: step_word = {ua, 16'h0000};
			fsl_pkg::OP_IDENT_EXIT: step_word = {fsl_pkg::UNLOCK_A1, 8'h00, fsl_pkg::CMD_EXIT};
			fsl_pkg::OP_QUERY: step_word = {fsl_pkg::QUERY_ADDR, 8'h00, fsl_pkg::CMD_QUERY};
			fsl_pkg::OP_SUSPEND: step_word = {20'h00000, 8'h00, fsl_pkg::CMD_SUSPEND};
			fsl_pkg::OP_RESUME: step_word = {20'h00000, 8'h00, fsl_pkg::CMD_RESUME};
			fsl_pkg::OP_IDENT_ENTRY: if (k == 3'd2) begin
				step_word = {fsl_pkg::UNLOCK_A1, 8'h00, fsl_pkg::CMD_ENTRY};
			end
			fsl_pkg::OP_SECT_LOCK: if (k == 3'd2) begin
				step_word = {fsl_pkg::UNLOCK_A1, 8'h00, fsl_pkg::CMD_SETUP};
			end else if (k == 3'd5) begin
				step_word = {ua, 8'h00, fsl_pkg::CMD_LOCKDN};
			end
			fsl_pkg::OP_PROG_SECREG, fsl_pkg::OP_LOCK_SECREG: if (k == 3'd2) begin
				step_word = {fsl_pkg::UNLOCK_A1, 8'h00, fsl_pkg::CMD_SECREG};
			end else if (k == 3'd3) begin                 // Lock write keeps the bit low
				step_word = (op == fsl_pkg::OP_LOCK_SECREG) ?
					{fsl_pkg::SECREG_LCK, fsl_pkg::SECREG_LOCK_DATA} : {ua, ud};
			end
		endcase
	endfunction

	// Command decode; opcodes past the last are refused
	assign cmd_wr    = SW_WR && (SW_ADDR == fsl_pkg::REG_CMD);
	assign cmd_legal = SW_WDATA[3:0] <= 4'(fsl_pkg::OP_LOCK_SECREG);
	assign cmd_op    = fsl_pkg::fsl_op_t'(SW_WDATA[3:0]);

	// Exit writes reuse the single-cycle exit step
	assign eng_op    = (state_q == S_EXIT) ? fsl_pkg::OP_IDENT_EXIT : op_q;
	assign eng_step  = (state_q == S_EXIT) ? 3'd0 : step_q;
	assign eng_start = (state_q == S_EXIT) || (state_q == S_STEP);
	assign eng_word  = step_word(eng_op, eng_step, uaddr_q, udata_q);

	fsl_bus_cycle u_cycle (
		.clk        (CLK_SYS),
		.rst        (RESET),
		.start      (eng_start),
		.is_read    (eng_op == fsl_pkg::OP_READ || eng_op == fsl_pkg::OP_STATUS),
		.addr       (eng_word[35:16]),
		.wdata      (eng_word[15:0]),
		.done       (eng_done),
		.rdata      (eng_rdata),
		.rdy_s      (rdy_s),
		.fl_addr    (FL_ADDR),
		.fl_dq_o    (FL_DQ_O),
		.fl_dq_oe_n (FL_DQ_OE_N),
		.fl_dq_i    (FL_DQ_I),
		.fl_ce_n    (FL_CE_N),
		.fl_we_n    (FL_WE_N),
		.fl_oe_n    (FL_OE_N),
		.fl_ready   (FL_READY)
	);

	// Device reset follows the system reset
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			FL_RESET_N <= 1'b0;
		end else begin
			FL_RESET_N <= 1'b1;
		end
	end

	// Operand registers
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			uaddr_q <= 20'h00000;
			udata_q <= 16'h0000;
		end else if (SW_WR && SW_ADDR == fsl_pkg::REG_ADDR) begin
			uaddr_q <= SW_WDATA[19:0];
		end else if (SW_WR && SW_ADDR == fsl_pkg::REG_WDATA) begin
			udata_q <= SW_WDATA[15:0];
		end
	end

	// Error flag: a refusal in the clearing cycle still sets it
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			err_q <= 1'b0;
		end else if (cmd_wr && (state_q != S_IDLE || !cmd_legal)) begin
			err_q <= 1'b1;
		end else if (SW_WR && SW_ADDR == fsl_pkg::REG_STATUS) begin
			err_q <= 1'b0;
		end
	end

	// Sequencer: optional exit, the operation's cycles, then follow-up
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			state_q <= S_IDLE;
			op_q <= fsl_pkg::OP_READ;
			step_q <= 3'd0;
			exit_q <= 1'b0;
			post_q <= 1'b0;
			mode_q <= 1'b0;
			fail_q <= 1'b0;
			vpp_q <= 1'b0;
			susp_q <= 1'b0;
			cnt_q <= 16'h0000;
			rdata_q <= 16'h0000;
		end else begin
			unique case (state_q)
				S_IDLE: if (cmd_wr && cmd_legal) begin
					op_q <= cmd_op;
					step_q <= 3'd0;
					post_q <= 1'b0;
					// Leave identification mode before any operation past query (suspend, resume, lockdown, security register)
					if (mode_q && cmd_op > fsl_pkg::OP_QUERY) begin
						state_q <= S_EXIT;
					end else begin
						state_q <= S_STEP;
					end
				end
				S_EXIT: begin
					exit_q <= 1'b1;
					state_q <= S_WAIT;
				end
				S_STEP: state_q <= S_WAIT;
				S_WAIT: if (eng_done) begin
					if (exit_q) begin                    // Exit finished, back in read mode
						exit_q <= 1'b0;
						mode_q <= 1'b0;
						state_q <= post_q ? S_IDLE : S_STEP;
					end else if (step_q != op_len(op_q) - 3'd1) begin
						step_q <= step_q + 3'd1;
						state_q <= S_STEP;
					end else begin
						state_q <= S_IDLE;
						unique case (op_q)
							fsl_pkg::OP_READ: rdata_q <= eng_rdata;
							fsl_pkg::OP_STATUS: begin
								rdata_q <= eng_rdata;
								fail_q <= eng_rdata[fsl_pkg::DQ_FAIL_BIT];
								vpp_q <= eng_rdata[fsl_pkg::DQ_VPP_BIT];
								state_q <= S_CHECK;
							end
							fsl_pkg::OP_IDENT_ENTRY, fsl_pkg::OP_QUERY: mode_q <= 1'b1;
							fsl_pkg::OP_IDENT_EXIT: mode_q <= 1'b0;
							fsl_pkg::OP_SUSPEND: begin       // Give the device its latency
								cnt_q <= 16'(SUSP_WAIT - 1);
								state_q <= S_SUSP;
							end
							fsl_pkg::OP_RESUME: susp_q <= 1'b0;
							default: ;
						endcase
					end
				end
				// A set failure or supply flag leaves the device in status mode
				S_CHECK: if (fail_q || vpp_q) begin
					post_q <= 1'b1;
					state_q <= S_EXIT;
				end else begin
					state_q <= S_IDLE;
				end
				S_SUSP: if (cnt_q == 16'h0000) begin  // Worst-case suspend time has passed
					susp_q <= 1'b1;
					state_q <= S_IDLE;
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// Register read port, data one cycle after the strobe
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			SW_RDATA <= 32'h00000000;
		end else if (SW_RD && SW_ADDR == fsl_pkg::REG_STATUS) begin
			SW_RDATA <= {25'h0000000, err_q, susp_q, mode_q, vpp_q, fail_q, rdy_s,
				state_q != S_IDLE};
		end else if (SW_RD && SW_ADDR == fsl_pkg::REG_RDATA) begin
			SW_RDATA <= {16'h0000, rdata_q};
		end else if (SW_RD && SW_ADDR == fsl_pkg::REG_ADDR) begin
			SW_RDATA <= {12'h000, uaddr_q};
		end else begin
			SW_RDATA <= 32'h00000000;
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);

	chk_fail_exit: assert property (state_q == S_CHECK && fail_q |=>
		state_q == S_EXIT ##1 state_q == S_WAIT && exit_q)
		else $error("Failure flag not followed by an exit write");
	chk_vpp_exit: assert property (state_q == S_CHECK && vpp_q |=>
		state_q == S_EXIT && post_q)
		else $error("Supply-low flag not followed by an exit write");
	chk_resume_single: assert property (state_q == S_WAIT && eng_done && !exit_q &&
		op_q == fsl_pkg::OP_RESUME |-> step_q == 3'd0 ##1 state_q == S_IDLE && !susp_q)
		else $error("Resume was not a single write");
	chk_suspend_wait: assert property (state_q == S_WAIT && eng_done && !exit_q &&
		op_q == fsl_pkg::OP_SUSPEND |-> step_q == 3'd0 ##1 state_q == S_SUSP && !susp_q)
		else $error("Suspend was not a single write followed by the wait");
	chk_lock_bit: assert property ($fell(FL_WE_N) && op_q == fsl_pkg::OP_LOCK_SECREG &&
		step_q == 3'd3 && !exit_q |-> !FL_DQ_O[fsl_pkg::DQ_LOCK_BIT])
		else $error("Security lock write with lock bit high");
	chk_mode_exit: assert property (state_q == S_IDLE && cmd_wr && cmd_legal && mode_q &&
		cmd_op > fsl_pkg::OP_QUERY |=> state_q == S_EXIT)
		else $error("Operation started in identification mode");
	chk_low_byte: assert property (eng_start && !(eng_op == fsl_pkg::OP_PROG_SECREG &&
		eng_step == 3'd3) && !(eng_op == fsl_pkg::OP_LOCK_SECREG && eng_step == 3'd3) &&
		eng_op != fsl_pkg::OP_READ && eng_op != fsl_pkg::OP_STATUS |-> eng_word[15:8] == 8'h00)
		else $error("Command code with upper byte set");

	cov_fail_exit: cover property (state_q == S_CHECK && fail_q ##1 state_q == S_EXIT);
	cov_suspend: cover property ($rose(susp_q));
	cov_sect_lock: cover property (eng_done && op_q == fsl_pkg::OP_SECT_LOCK && step_q == 3'd5);

endmodule

// [pkg/fsl_pkg.sv]
// Shared constants for the flash command host: software register map,
// operation codes, device command words and pin timing.
// Assumes a 10 MHz system clock and a word-wide flash data bus.
package fsl_pkg;

	// Flash bus widths
	localparam int ADDR_W = 20;                    // Flash word address width
	localparam int DATA_W = 16;                    // Flash data width

	// Software register offsets
	localparam logic [2:0] REG_CMD    = 3'h0;      // Write: start an operation
	localparam logic [2:0] REG_ADDR   = 3'h1;      // Operand address
	localparam logic [2:0] REG_WDATA  = 3'h2;      // Operand data
	localparam logic [2:0] REG_STATUS = 3'h3;      // Read: state, write: clear error
	localparam logic [2:0] REG_RDATA  = 3'h4;      // Last word read from the flash

	// Status register bit positions
	localparam int ST_BUSY = 0;                    // Sequencer working
	localparam int ST_RDY  = 1;                    // Synchronised ready/busy line
	localparam int ST_FAIL = 2;                    // Last status read showed op_fail_flag
	localparam int ST_VPP  = 3;                    // Last status read showed supply_low_flag
	localparam int ST_MODE = 4;                    // Device in identification or query mode
	localparam int ST_SUSP = 5;                    // Program or erase suspended
	localparam int ST_ERR  = 6;                    // Command refused

	// Operations software may order
	typedef enum logic [3:0] {
		OP_READ, OP_STATUS, OP_IDENT_ENTRY, OP_IDENT_EXIT, OP_QUERY,
		OP_SUSPEND, OP_RESUME, OP_SECT_LOCK, OP_PROG_SECREG, OP_LOCK_SECREG
	} fsl_op_t;

	// Device status bits and lock bit on the data bus
	localparam int DQ_FAIL_BIT = 5;                // op_fail_flag
	localparam int DQ_VPP_BIT  = 3;                // supply_low_flag
	localparam int DQ_LOCK_BIT = 1;                // lock_data_bit

	// Device command addresses and codes
	localparam logic [ADDR_W-1:0] UNLOCK_A1  = 20'h00555;  // First unlock address
	localparam logic [ADDR_W-1:0] UNLOCK_A2  = 20'h00aaa;  // Second unlock address
	localparam logic [ADDR_W-1:0] QUERY_ADDR = 20'h00055;  // Query entry address
	localparam logic [ADDR_W-1:0] SECREG_LCK = 20'h00080;  // User half lock location
	localparam logic [7:0] CMD_UNLK1   = 8'haa;    // Unlock code one
	localparam logic [7:0] CMD_UNLK2   = 8'h55;    // Unlock code two
	localparam logic [7:0] CMD_SETUP   = 8'h80;    // Extended setup
	localparam logic [7:0] CMD_LOCKDN  = 8'h60;    // Sector lockdown
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;    // Erase/program suspend
	localparam logic [7:0] CMD_RESUME  = 8'h30;    // Erase/program resume
	localparam logic [7:0] CMD_QUERY   = 8'h98;    // Query entry
	localparam logic [7:0] CMD_ENTRY   = 8'h90;    // ident_mode_entry
	localparam logic [7:0] CMD_EXIT    = 8'hf0;    // ident_mode_exit
	localparam logic [7:0] CMD_SECREG  = 8'hc0;    // Security register program/lock
	localparam logic [DATA_W-1:0] SECREG_LOCK_DATA = 16'hfffd;  // lock_data_bit low

	// Timing
	localparam int CLK_NS      = 100;              // System clock period
	localparam int PULSE_NS    = 100;              // Least strobe low time
	localparam int ERS_SUSP_US = 15;               // Longest erase suspend latency
	localparam int PRG_SUSP_US = 20;               // Longest program suspend latency
	localparam int PULSE_CYC   = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SUSP_US     = (ERS_SUSP_US > PRG_SUSP_US) ? ERS_SUSP_US : PRG_SUSP_US;
	localparam int SUSP_CYC    = (SUSP_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_CYC    = 2;                // Extra read strobe for input sync

endpackage

// [design/fsl_bus_cycle.sv]
// One asynchronous flash bus cycle, write or read, on the device pins.
// Assumes a one-cycle start pulse while idle; pin inputs are synchronised here.
`timescale 1ns/100ps
module fsl_bus_cycle #(
	parameter int PULSE = fsl_pkg::PULSE_CYC       // Strobe low cycles
) (
	input  wire logic        clk,                  // System clock
	input  wire logic        rst,                  // Synchronous reset, high
	input  wire logic        start,                // Start a cycle (idle only)
	input  wire logic        is_read,              // Read rather than write
	input  wire logic [19:0] addr,                 // Cycle address
	input  wire logic [15:0] wdata,                // Write data
	output logic             done,                 // Cycle finished, one pulse
	output logic      [15:0] rdata,                // Captured read data
	output logic             rdy_s,                // Synchronised ready line
	output logic      [19:0] fl_addr,              // Flash address pins
	output logic      [15:0] fl_dq_o,              // Flash data out
	output logic             fl_dq_oe_n,           // Low while driving data
	input  wire logic [15:0] fl_dq_i,              // Flash data in
	output logic             fl_ce_n,              // Chip select, low
	output logic             fl_we_n,              // Write strobe, low
	output logic             fl_oe_n,              // Output enable, low
	input  wire logic        fl_ready              // Open-drain ready/busy line
);
	typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} fsl_est_t;

	localparam logic [7:0] WR_LEN = 8'(PULSE - 1);                   // Write strobe
	localparam logic [7:0] RD_LEN = 8'(PULSE + fsl_pkg::SYNC_CYC - 1); // Read strobe

	fsl_est_t    st_q;                             // Cycle phase
	logic [7:0]  cnt_q;                            // Strobe countdown
	logic        rd_q;                             // Current cycle is a read
	logic [15:0] dq_s1_q, dq_s2_q;                 // Data input synchroniser
	logic        rdy_s1_q, rdy_s2_q;               // Ready input synchroniser

	// Two flops on every pin input; only the second is read
	always_ff @(posedge clk) begin
		if (rst) begin
			dq_s1_q  <= 16'h0000;
			dq_s2_q  <= 16'h0000;
			rdy_s1_q <= 1'b0;
			rdy_s2_q <= 1'b0;
		end else begin
			dq_s1_q  <= fl_dq_i;
			dq_s2_q  <= dq_s1_q;
			rdy_s1_q <= fl_ready;
			rdy_s2_q <= rdy_s1_q;
		end
	end

	assign rdy_s = rdy_s2_q;

	// Address set before the strobe falls, data held past its rise
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= E_IDLE;
			cnt_q <= 8'h00;
			rd_q <= 1'b0;
			done <= 1'b0;
			rdata <= 16'h0000;
			fl_addr <= 20'h00000;
			fl_dq_o <= 16'h0000;
			fl_dq_oe_n <= 1'b1;
			fl_ce_n <= 1'b1;
			fl_we_n <= 1'b1;
			fl_oe_n <= 1'b1;
		end else begin
			done <= 1'b0;
			unique case (st_q)
				E_IDLE: if (start) begin                // Present address, select chip
					st_q <= E_SETUP;
					rd_q <= is_read;
					fl_addr <= addr;
					fl_dq_o <= wdata;
					fl_dq_oe_n <= is_read;
					fl_ce_n <= 1'b0;
				end
				E_SETUP: begin                          // Strobe falls after address is stable
					st_q <= E_STROBE;
					cnt_q <= rd_q ? RD_LEN : WR_LEN;
					fl_we_n <= rd_q;
					fl_oe_n <= !rd_q;
				end
				E_STROBE: if (cnt_q == 8'h00) begin    // Write strobe rises before select
					st_q <= E_HOLD;
					fl_we_n <= 1'b1;
					fl_oe_n <= 1'b1;
					if (rd_q) begin
						rdata <= dq_s2_q;
					end
				end else begin
					cnt_q <= cnt_q - 8'h01;
				end
				E_HOLD: begin                           // Release the bus after data hold
					st_q <= E_IDLE;
					fl_ce_n <= 1'b1;
					fl_dq_oe_n <= 1'b1;
					done <= 1'b1;
				end
			endcase
		end
	end

	chk_addr_setup: assert property (@(posedge clk) disable iff (rst)
		$fell(fl_we_n) |-> $past(!fl_ce_n) && $stable(fl_addr) && !fl_dq_oe_n)
		else $error("Write strobe fell without stable address and select");

	chk_data_hold: assert property (@(posedge clk) disable iff (rst)
		$rose(fl_we_n) |-> !fl_ce_n && !fl_dq_oe_n && $stable(fl_dq_o) ##1 fl_ce_n)
		else $error("Data not held across the write strobe rise");

endmodule

// [sim/fsl_flash_model.sv]
// Behavioural flash device facing the host: decodes commands, keeps lockdown,
// security lock, query mode and the open-drain ready line with its pull-up.
// Assumes the host drives the pins directly and writes whole 16-bit words.
`timescale 1ns/100ps
module fsl_flash_model (
	input  wire logic [19:0] a,     // Address pins
	input  wire logic [15:0] d,     // Data from host
	input  wire logic        ce_n,  // Chip select
	input  wire logic        we_n,  // Write strobe
	input  wire logic        oe_n,  // Output enable
	input  wire logic        rst_n, // Device reset
	input  wire logic        vpp_ok, // Program supply adequate
	output logic      [15:0] q,     // Data to host
	output logic             rdy    // Ready line after pull-up
);
	logic [31:0] lock_q = '0;       // One lock bit per sector
	logic [19:0] al;                // Address latched at strobe fall
	logic [7:0]  c0, c1, c2;        // Earlier codes, newest first
	logic        ident = 0;         // Identification or query mode
	logic        sec_open = 1;      // User half still programmable
	logic        fail = 0;          // Refused or failed operation
	logic        vlow = 0;          // Program attempted with supply too low
	logic        busy = 0;          // Internal cycle running
	logic [15:0] last = '0;         // Last value driven
	event        work;              // Start of an internal cycle
	// Pull-up wins unless the device sinks the line
	assign rdy = busy ? 1'b0 : 1'b1;
	// Host strobe falls after select, so this is the later fall
	always @(negedge we_n) al = a;
	// Command decode on strobe rise, upper byte ignored
	always @(posedge we_n) if (rst_n && !ce_n) begin
		if (c0 == 8'hc0) begin
			if (al == 20'h00080) begin if (!d[1]) sec_open = 0; end
			else if (!vpp_ok) vlow = 1;
			else if (sec_open) ->work;
			else fail = 1;
		end else case (d[7:0])
			8'hf0: begin ident = 0; fail = 0; vlow = 0; end
			8'h90: ident = 1;
			8'h98: if (al == 20'h00055) ident = 1;
			8'h60: if (c2 == 8'h80 && c0 == 8'h55) lock_q[al[19:15]] = 1;
			8'hb0: busy = 0;
			default: ;
		endcase
		c2 = c1;
		c1 = c0;
		c0 = d[7:0];
	end
	// Only a reset unlocks sectors
	always @(negedge rst_n) begin lock_q = '0; ident = 0; fail = 0; vlow = 0; end
	always @(work) begin busy = 1; #3000 busy = 0; end
	// Released bus shows the inverse so a stale value never passes
	always @* begin
		if (!ce_n && !oe_n && rst_n) begin
			if ((fail || vlow) && !busy) q = {10'h000, fail, 1'b0, vlow, 3'h0};
			else if (ident && a == 20'h00080) q = {14'h3fff, sec_open, 1'b1};
			else if (ident && a[14:0] == 15'h0002) q = {15'h0, lock_q[a[19:15]]};
			else q = a[15:0] ^ 16'h5a5a;
			last = q;
		end else q = ~last;
	end
endmodule

// [sim/fsl_host_ctrl_tb_top.sv]
// Self-checking bench for the flash host: register tasks drive operations
// and compare status and read data. Assumes the device model beside it.
`timescale 1ns/100ps
module fsl_host_ctrl_tb_top;
	logic        clk = 0, rst = 1, wr = 0, rd = 0, rdy; // Clock, reset, strobes
	logic [2:0]  sa = '0;          // Register offset
	logic [31:0] wd = '0, got, sd; // Write data, sampled read data
	logic [19:0] fa;               // Flash pins
	logic [15:0] fo, fi;
	logic        oe, ce, we, fo_n, frn;
	logic        vok = 1;          // Model program supply adequate
	int          err_count = 0, checked = 0;
	always #50 clk = ~clk;
	fsl_host_ctrl #(.SUSP_WAIT(4)) i_dut (.CLK_SYS(clk), .RESET(rst), .SW_ADDR(sa),
		.SW_WDATA(wd), .SW_WR(wr), .SW_RD(rd), .SW_RDATA(sd), .FL_ADDR(fa), .FL_DQ_O(fo),
		.FL_DQ_I(fi), .FL_DQ_OE_N(oe), .FL_CE_N(ce), .FL_WE_N(we), .FL_OE_N(fo_n),
		.FL_RESET_N(frn), .FL_READY(rdy));
	fsl_flash_model i_dev (.a(fa), .d(fo), .ce_n(ce), .we_n(we), .oe_n(fo_n),
		.rst_n(frn), .vpp_ok(vok), .q(fi), .rdy(rdy));
	task automatic tally_and_finish;
		$display("Checks %0d, errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin $display("Error %s expected %h seen %h", n, e, g); err_count++; end
	endtask
	task automatic wreg(input logic [2:0] a, input logic [31:0] v);
		@(posedge clk); sa <= a; wd <= v; wr <= 1;
		@(posedge clk); wr <= 0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic sread(input logic [2:0] a);
		@(posedge clk); sa <= a; rd <= 1;
		@(posedge clk); rd <= 0;
		#1 got = sd;
	endtask
	task automatic st(input logic [31:0] m, input logic [31:0] e, input string n);
		sread(fsl_pkg::REG_STATUS);
		check(n, e, got & m);
	endtask
	// Start an operation and poll busy under a bound
	task automatic op(input fsl_pkg::fsl_op_t o);
		int i;
		wreg(fsl_pkg::REG_CMD, {28'h0, o});
		repeat (2) @(posedge clk);
		for (i = 0; i < 500; i++) begin
			sread(fsl_pkg::REG_STATUS);
			if (got[0] === 1'b0) break;
		end
		if (i == 500) begin $display("Error busy timeout"); err_count++; tally_and_finish(); end
	endtask
	task automatic rmem(input logic [19:0] a, input logic [31:0] m, input logic [31:0] e,
		input string n);
		wreg(fsl_pkg::REG_ADDR, {12'h0, a});
		op(fsl_pkg::OP_READ);
		sread(fsl_pkg::REG_RDATA);
		check(n, e, got & m);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		repeat (3) @(posedge clk);
		st(32'h7f, 32'h02, "reset status");
		wreg(fsl_pkg::REG_ADDR, 32'h18000);
		op(fsl_pkg::OP_SECT_LOCK);
		op(fsl_pkg::OP_IDENT_ENTRY);
		rmem(20'h18002, 32'hffffffff, 32'h1, "locked sector");
		rmem(20'h08002, 32'hffffffff, 32'h0, "open sector");
		op(fsl_pkg::OP_SUSPEND);
		st(32'h30, 32'h20, "suspend");
		op(fsl_pkg::OP_RESUME);
		st(32'h20, 32'h0, "resume");
		op(fsl_pkg::OP_QUERY);
		st(32'h10, 32'h10, "query mode");
		op(fsl_pkg::OP_IDENT_EXIT);
		st(32'h10, 32'h0, "query exit");
		wreg(fsl_pkg::REG_WDATA, 32'h1234);
		wreg(fsl_pkg::REG_ADDR, 32'h00090);
		op(fsl_pkg::OP_PROG_SECREG);
		st(32'h02, 32'h0, "ready low");
		repeat (40) @(posedge clk);
		st(32'h02, 32'h02, "ready back");
		op(fsl_pkg::OP_LOCK_SECREG);
		op(fsl_pkg::OP_IDENT_ENTRY);
		rmem(20'h00080, 32'h2, 32'h0, "user half lock");
		wreg(fsl_pkg::REG_ADDR, 32'h00090);
		op(fsl_pkg::OP_PROG_SECREG);
		op(fsl_pkg::OP_STATUS);
		st(32'h14, 32'h04, "fail flag");
		rmem(20'h00010, 32'hffff, 32'h5a4a, "array after exit");
		vok <= 0;
		op(fsl_pkg::OP_PROG_SECREG);
		op(fsl_pkg::OP_STATUS);
		st(32'h0c, 32'h08, "supply low");
		vok <= 1;
		wreg(fsl_pkg::REG_CMD, 32'hf);
		st(32'h40, 32'h40, "refused code");
		wreg(fsl_pkg::REG_STATUS, 32'h0);
		st(32'h40, 32'h0, "error cleared");
		sread(3'h7);
		check("unmapped", 32'h0, got);
		@(posedge clk);
		rst <= 1;
		repeat (6) @(posedge clk);
		rst <= 0;
		repeat (3) @(posedge clk);
		op(fsl_pkg::OP_IDENT_ENTRY);
		rmem(20'h18002, 32'hffffffff, 32'h0, "lock after reset");
		tally_and_finish();
	end
endmodule
